// ==== err_pkg.sv ====
// package for the bit error counter with masking: constants, modes and carriers
// assumes a single 40 MHz system clock and synchronous pin inputs
package err_pkg;

  // system clock rate and interval times
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned T_1MS_US = 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
  localparam int unsigned CYC_1MS = T_1MS_US * CYC_PER_US;
  localparam int unsigned SEC_PER_MS = 1000;

  // phase offset limits, milli-UI
  localparam int PHASE_MIN_MUI = -1000;
  localparam int PHASE_MAX_MUI = 1000;
  localparam int PHASE_STEP_MUI = 2;
  localparam logic signed [11:0] PHASE_RESET = 12'sh000;

  // word mask segment width
  localparam int unsigned SEG_BITS = 32;

  // counter widths
  localparam int unsigned CNT_W = 32;

  typedef enum logic [0:0] {
    DET_INS_OMI,
    DET_TRANSITION
  } detect_mode_t;

  typedef enum logic [1:0] {
    IVL_1MS,
    IVL_10MS,
    IVL_100MS,
    IVL_1S
  } interval_sel_t;

  typedef enum logic [1:0] {
    PAT_PRBS,
    PAT_ZERO_SUB,
    PAT_DATA,
    PAT_MIXED
  } pattern_kind_t;

  // configuration written by the control side
  typedef struct packed {
    detect_mode_t detect;
    interval_sel_t interval;
    logic block_mask_en;
    logic word_mask_en;
    logic combined;
    pattern_kind_t pattern;
    logic capturing;
  } err_cfg_t;

  // one received bit with its expected value and mask settings
  typedef struct packed {
    logic valid;
    logic rx;
    logic expected;
    logic block_mask;
    logic first_of_word;
  } bit_in_t;

  // counters shown to the control side
  typedef struct packed {
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] zero_to_one_error;
    logic [CNT_W-1:0] one_to_zero_error;
    logic [CNT_W-1:0] transition;
    logic [CNT_W-1:0] non_transition;
    logic [CNT_W-1:0] errored_interval_count;
    logic [CNT_W-1:0] error_free_interval;
  } err_counts_t;

endpackage

// ==== word_mask_mem.sv ====
// small memory holding one enable bit per 32-bit pattern word
// assumes the write port and read port share clk_sys; read data are registered
`timescale 1ns/1ps
module word_mask_mem
  import err_pkg::*;
#(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW = 8
) (
  input wire logic clk_sys,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic rd_data
);

  initial begin
    if (DEPTH > (1 << AW) || DEPTH < 1) begin
      $error("word_mask_mem: DEPTH does not fit AW");
    end
  end

  logic mem [DEPTH];

  // memory content is undefined until software loads it; no reset on the array
  always_ff @(posedge clk_sys) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (ce) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // word_mask_mem

// ==== bit_error_counter_masking.sv ====
// error detection core: compares received bits with the expected pattern,
// classifies and counts errors, measures error intervals, applies masks.
// assumes rx/expected arrive synchronous to clk_sys, one bit per valid cycle,
// and the control side holds configuration steady apart from its own writes.
//
// Functional notes
// - insertion mode: expected 0, received 1 counts as zero-to-one error
// - insertion mode: expected 1, received 0 counts as one-to-zero error
// - transition mode: errors counted apart on transition and non-transition bits
// - transition mode is refused while lanes are combined
// - interval periods 1, 10, 100 ms; counter counts errored periods
// - 1 s period: one count per second whose accumulated count is nonzero
// - block mask on: bits whose mask setting is one are excluded
// - block mask off: every bit is measured, bar those in a word segment the word mask disables
// - block mask cannot be configured with pseudo-random or mixed pattern
// - block mask configuration frozen once capture has begun; a write selecting prbs or mixed pattern still drops it
// - word mask on: each 32-bit segment enabled or disabled separately
// - phase offset accepted from -1000 to +1000 mUI in 2 mUI steps
// - phase held in mUI; femtoseconds derived from current bit rate
`timescale 1ns/1ps
module bit_error_counter_masking
  import err_pkg::*;
#(
  parameter int unsigned WORDS = 256,
  parameter int unsigned WAW = 8,
  parameter int unsigned CYC_PER_MS = CYC_1MS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire err_cfg_t cfg_req,
  input wire logic cfg_wr,
  input wire bit_in_t bit_in,
  input wire logic wmask_wr,
  input wire logic [WAW-1:0] wmask_addr,
  input wire logic wmask_data,
  input wire logic signed [11:0] phase_req,
  input wire logic phase_wr,
  input wire logic [31:0] bit_period_fs,
  input wire logic clear_counts,
  output err_cfg_t cfg,
  output logic cfg_refused,
  output logic signed [11:0] phase_mui,
  output logic signed [31:0] phase_fs,
  output logic phase_refused,
  output err_counts_t counts,
  output logic error_seen
);

  initial begin
    if (WORDS > (1 << WAW) || CYC_PER_MS < 1) begin
      $error("bit_error_counter_masking: bad parameters");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and phase

  err_cfg_t next_cfg;
  logic next_cfg_refused;
  logic signed [11:0] next_phase_mui;
  logic next_phase_refused;
  logic signed [31:0] next_phase_fs;

  // configuration writes: refused bits keep their old value
  always_comb begin
    next_cfg = cfg;
    next_cfg_refused = 1'b0;
    next_phase_mui = phase_mui;
    next_phase_refused = 1'b0;
    if (cfg_wr) begin
      next_cfg = cfg_req;
      if (cfg_req.combined && cfg_req.detect == DET_TRANSITION) begin
        next_cfg.detect = cfg.detect;
        next_cfg_refused = 1'b1;
      end
      if (cfg_req.block_mask_en != cfg.block_mask_en
          && (cfg_req.pattern == PAT_PRBS || cfg_req.pattern == PAT_MIXED)) begin
        next_cfg.block_mask_en = cfg.block_mask_en;
        next_cfg_refused = 1'b1;
      end
      if (cfg_req.block_mask_en != cfg.block_mask_en && cfg.capturing) begin
        next_cfg.block_mask_en = cfg.block_mask_en;
        next_cfg_refused = 1'b1;
      end
    end
    // mask dropped when pattern forbids it
    if (next_cfg.pattern == PAT_PRBS || next_cfg.pattern == PAT_MIXED) begin
      next_cfg.block_mask_en = 1'b0;
    end
    if (phase_wr) begin
      if (phase_req < 12'(PHASE_MIN_MUI) || phase_req > 12'(PHASE_MAX_MUI)
          || phase_req[0] != 1'b0) begin
        next_phase_refused = 1'b1;
      end else begin
        next_phase_mui = phase_req;
      end
    end
    // femtoseconds follow bit rate (femtoseconds = mUI * period / 1000)
    next_phase_fs = 32'(($signed({1'b0, bit_period_fs}) * 44'(phase_mui)) / 1000);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
      cfg_refused <= 1'b0;
      phase_mui <= PHASE_RESET;
      phase_refused <= 1'b0;
      phase_fs <= 32'sh0;
    end else if (ce) begin
      cfg <= next_cfg;
      cfg_refused <= next_cfg_refused;
      phase_mui <= next_phase_mui;
      phase_refused <= next_phase_refused;
      phase_fs <= next_phase_fs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word mask memory and word position

  logic [WAW-1:0] word_idx;
  logic [WAW-1:0] next_word_idx;
  logic [WAW-1:0] fetch_idx;
  logic word_en;
  logic cur_word_en;
  logic next_cur_word_en;
  logic word_open;
  logic mem_wr;

  // index of the word that follows idx, wrapping after the last word
  function automatic logic [WAW-1:0] word_after(input logic [WAW-1:0] idx);
    word_after = (idx == WAW'(WORDS - 1)) ? '0 : WAW'(idx + 1'b1);
  endfunction

  // mask memory also frozen during capture
  assign mem_wr = wmask_wr && !cfg.capturing;

  word_mask_mem #(.DEPTH(WORDS), .AW(WAW)) u_mem (
    .clk_sys(clk_sys),
    .ce(ce),
    .wr_en(mem_wr),
    .wr_addr(wmask_addr),
    .wr_data(wmask_data),
    .rd_addr(fetch_idx),
    .rd_data(word_en)
  );

  // the memory always prefetches the word after the current one, because its
  // read data arrive a cycle late; the first bit of a word uses that prefetch
  always_comb begin
    next_word_idx = word_idx;
    next_cur_word_en = cur_word_en;
    word_open = cur_word_en;
    if (bit_in.valid && bit_in.first_of_word) begin
      next_word_idx = word_after(word_idx);
      word_open = word_en;
      next_cur_word_en = word_en;
    end
    fetch_idx = word_after(next_word_idx);
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and classify

  logic prev_exp;
  logic next_prev_exp;
  logic mism;
  logic measured;
  err_counts_t next_counts;
  logic next_error_seen;

  function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v, input logic en);
    inc = (en && v != '1) ? CNT_W'(v + 1'b1) : v;
  endfunction

  // interval length in ms for each period choice
  function automatic logic [9:0] ivl_len(input interval_sel_t s);
    case (s)
      IVL_1MS: ivl_len = 10'h001;
      IVL_10MS: ivl_len = 10'h00A;
      IVL_100MS: ivl_len = 10'h064;
      IVL_1S: ivl_len = 10'(SEC_PER_MS);
      default: ivl_len = 10'h001;
    endcase
  endfunction

  // interval timing
  logic [CNT_W-1:0] ms_cyc, next_ms_cyc;
  logic [9:0] ms_in_ivl, next_ms_in_ivl;
  logic ivl_err, next_ivl_err;

  always_comb begin
    next_prev_exp = bit_in.valid ? bit_in.expected : prev_exp;
    mism = bit_in.valid && (bit_in.rx != bit_in.expected);
    measured = mism && !(cfg.block_mask_en && bit_in.block_mask)
               && !(cfg.word_mask_en && !word_open);
    next_counts = counts;
    next_error_seen = measured;
    next_counts.total = inc(counts.total, measured);
    if (cfg.detect == DET_INS_OMI) begin
      next_counts.zero_to_one_error = inc(counts.zero_to_one_error,
                                          measured && !bit_in.expected);
      next_counts.one_to_zero_error = inc(counts.one_to_zero_error,
                                          measured && bit_in.expected);
    end else begin
      next_counts.transition = inc(counts.transition,
                                   measured && (bit_in.expected != prev_exp));
      next_counts.non_transition = inc(counts.non_transition,
                                       measured && (bit_in.expected == prev_exp));
    end
    // interval machinery: 1 ms tick, then period length in ms
    next_ms_cyc = ms_cyc;
    next_ms_in_ivl = ms_in_ivl;
    next_ivl_err = ivl_err || measured;
    if (ms_cyc == CNT_W'(CYC_PER_MS - 1)) begin
      next_ms_cyc = '0;
      if (ms_in_ivl == ivl_len(cfg.interval)) begin
        next_ms_in_ivl = 10'h001;
        // errored or error free; an error in the last cycle still counts
        next_counts.errored_interval_count = inc(counts.errored_interval_count,
                                                 ivl_err || measured);
        next_counts.error_free_interval = inc(counts.error_free_interval,
                                              !(ivl_err || measured));
        next_ivl_err = 1'b0;
      end else begin
        next_ms_in_ivl = 10'(ms_in_ivl + 1'b1);
      end
    end else begin
      next_ms_cyc = CNT_W'(ms_cyc + 1'b1);
    end
    if (clear_counts) begin
      next_counts = '0;
      next_ms_cyc = '0;
      next_ms_in_ivl = 10'h001;
      next_ivl_err = 1'b0;
    end
  end

  // counters saturate rather than wrap, so a long run never reads as clean
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counts <= '0;
      error_seen <= 1'b0;
      prev_exp <= 1'b0;
      word_idx <= '0;
      cur_word_en <= 1'b0;
      ms_cyc <= '0;
      ms_in_ivl <= 10'h001;
      ivl_err <= 1'b0;
    end else if (ce) begin
      counts <= next_counts;
      error_seen <= next_error_seen;
      prev_exp <= next_prev_exp;
      word_idx <= next_word_idx;
      cur_word_en <= next_cur_word_en;
      ms_cyc <= next_ms_cyc;
      ms_in_ivl <= next_ms_in_ivl;
      ivl_err <= next_ivl_err;
    end
  end

endmodule // bit_error_counter_masking

// ==== pattern_source.sv ====
// model of the device under test that sends the serial pattern, one bit per request
// assumes the bench changes its requests just after a rising edge of clk_sys
`timescale 1ns/1ps
module pattern_source
  import err_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic send,
  input wire logic flip,
  input wire logic exp_bit,
  input wire logic bmask,
  input wire logic first,
  output bit_in_t bit_out
);
  // registered bit; an idle line toggles so a stale level never looks like data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_out <= '0;
    end else if (send) begin
      bit_out <= '{1'b1, exp_bit ^ flip, exp_bit, bmask, first};
    end else begin
      bit_out <= '{1'b0, ~bit_out.rx, ~bit_out.expected, 1'b0, 1'b0};
    end
  end
endmodule // pattern_source

// ==== bit_error_counter_masking_props.sv ====
// concurrent checks on the ports of the bit error counter
// assumes one clock domain and ce held high by the bench
`timescale 1ns/1ps
module bit_error_counter_masking_props
  import err_pkg::*;
#(
  parameter int unsigned WORDS = 256,
  parameter int unsigned WAW = 8,
  parameter int unsigned CYC_PER_MS = CYC_1MS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire err_cfg_t cfg_req,
  input wire logic cfg_wr,
  input wire bit_in_t bit_in,
  input wire logic wmask_wr,
  input wire logic [WAW-1:0] wmask_addr,
  input wire logic wmask_data,
  input wire logic signed [11:0] phase_req,
  input wire logic phase_wr,
  input wire logic [31:0] bit_period_fs,
  input wire logic clear_counts,
  input wire err_cfg_t cfg,
  input wire logic cfg_refused,
  input wire logic signed [11:0] phase_mui,
  input wire logic signed [31:0] phase_fs,
  input wire logic phase_refused,
  input wire err_counts_t counts,
  input wire logic error_seen
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // a mismatching bit taken this cycle, and whether no mask may hide it
  wire bad = ce && bit_in.valid && (bit_in.rx != bit_in.expected) && !clear_counts;
  wire open_bit = !cfg.word_mask_en && !(cfg.block_mask_en && bit_in.block_mask);
  wire ph_bad = phase_req > 12'sd1000 || phase_req < -12'sd1000 || phase_req[0];
  // phase write in two steps: accepted value, then the derived femtoseconds
  sequence s_take;
    ce && phase_wr && !ph_bad;
  endsequence
  sequence s_fs;
    phase_fs == longint'(phase_mui) * longint'(bit_period_fs) / 1000;
  endsequence
  AST_ZERO_TO_ONE: assert property (bad && open_bit && cfg.detect == DET_INS_OMI
    && !bit_in.expected |=> counts.zero_to_one_error == $past(counts.zero_to_one_error) + 1)
    else $error("zero to one error not counted");
  AST_ONE_TO_ZERO: assert property (bad && open_bit && cfg.detect == DET_INS_OMI
    && bit_in.expected |=> counts.one_to_zero_error == $past(counts.one_to_zero_error) + 1)
    else $error("one to zero error not counted");
  AST_TRANS_SPLIT: assert property (bad && open_bit && cfg.detect == DET_TRANSITION |=>
    counts.transition + counts.non_transition
    == $past(counts.transition + counts.non_transition) + 1)
    else $error("transition class count wrong");
  AST_NO_TRANS_COMBINED: assert property (ce && cfg_wr && cfg_req.combined
    && cfg_req.detect == DET_TRANSITION |=> cfg_refused && cfg.detect == $past(cfg.detect))
    else $error("transition mode taken while combined");
  AST_BLOCK_MASKED: assert property (bad && cfg.block_mask_en && bit_in.block_mask |=>
    !error_seen && counts.total == $past(counts.total))
    else $error("masked bit was counted");
  AST_NO_MASK_COUNTS: assert property (bad && !cfg.block_mask_en && !cfg.word_mask_en |=>
    error_seen && counts.total == $past(counts.total) + 1)
    else $error("unmasked error not counted");
  AST_BM_PATTERN: assert property ((cfg.pattern == PAT_PRBS || cfg.pattern == PAT_MIXED)
    |-> !cfg.block_mask_en)
    else $error("block mask on with random pattern");
  AST_BM_FROZEN: assert property (ce && cfg_wr && cfg.capturing |=>
    cfg.block_mask_en == $past(cfg.block_mask_en))
    else $error("block mask changed while capturing");
  AST_PHASE_RANGE: assert property (ce && phase_wr && ph_bad |=>
    phase_refused && phase_mui == $past(phase_mui))
    else $error("bad phase value taken");
  AST_PHASE_FS: assert property (s_take |=> phase_mui == $past(phase_req) ##1 s_fs)
    else $error("phase in femtoseconds wrong");
endmodule // bit_error_counter_masking_props

bind bit_error_counter_masking bit_error_counter_masking_props #(.WORDS(WORDS), .WAW(WAW),
  .CYC_PER_MS(CYC_PER_MS)) u_bit_error_counter_masking_props (.*);

// ==== test_bit_error_counter_masking.sv ====
// self-checking bench for the bit error counter with masking
// assumes pattern_source and the bound checker are compiled before it
`timescale 1ns/1ps
module test_bit_error_counter_masking;
  import err_pkg::*;
  logic clk_sys, rst_n, ce, cfg_wr, wmask_wr, wmask_data, phase_wr, clear_counts;
  logic send, flip, exp_bit, bmask, first, cfg_refused, phase_refused, error_seen;
  logic prv, bm_on, wm_on, rf, bad;
  logic [7:0] wmask_addr, widx;
  logic signed [11:0] phase_req, phase_mui;
  logic signed [31:0] phase_fs;
  logic [31:0] bit_period_fs, r, nb;
  logic wmem [256];
  detect_mode_t md;
  err_cfg_t cfg_req, cfg, c, w;
  bit_in_t bit_in;
  err_counts_t counts, ec, nt;
  err_counts_t q[$];
  int n_errors, checks, pm;
  int pv[8] = '{1000, -1000, 1002, -1002, 3, 2, -2, 0};
  pattern_source u_pattern_source (.clk_sys(clk_sys), .rst_n(rst_n), .send(send), .flip(flip),
    .exp_bit(exp_bit), .bmask(bmask), .first(first), .bit_out(bit_in));
  bit_error_counter_masking #(.CYC_PER_MS(10)) u_bit_error_counter_masking (.clk_sys(clk_sys),
    .rst_n(rst_n), .ce(ce), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .bit_in(bit_in),
    .wmask_wr(wmask_wr), .wmask_addr(wmask_addr), .wmask_data(wmask_data),
    .phase_req(phase_req), .phase_wr(phase_wr), .bit_period_fs(bit_period_fs),
    .clear_counts(clear_counts), .cfg(cfg), .cfg_refused(cfg_refused), .phase_mui(phase_mui),
    .phase_fs(phase_fs), .phase_refused(phase_refused), .counts(counts),
    .error_seen(error_seen));
  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // write config; the refusal pulse is gathered over two cycles, its edge being a choice
  task automatic wcfg(input err_cfg_t rq, input logic rexp, input err_cfg_t want);
    cfg_req <= rq;
    cfg_wr <= 1'b1;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    @(negedge clk_sys);
    rf = cfg_refused;
    @(negedge clk_sys);
    chk(rf | cfg_refused, rexp);
    chk(cfg, want);
    md = want.detect;
    bm_on = want.block_mask_en;
    wm_on = want.word_mask_en;
    @(posedge clk_sys);
  endtask
  task automatic clr();
    clear_counts <= 1'b1;
    @(posedge clk_sys);
    clear_counts <= 1'b0;
    ec = '0;
  endtask
  // send one bit and note the counts it should leave behind
  task automatic bit1(input logic f, input logic m);
    r = lfsr(r);
    if (nb[4:0] == 5'h00) widx++;
    if (f && !(bm_on && m) && !(wm_on && !wmem[widx])) begin
      ec.total += 1;
      if (md == DET_TRANSITION && r[0] != prv) ec.transition += 1;
      if (md == DET_TRANSITION && r[0] == prv) ec.non_transition += 1;
      if (md == DET_INS_OMI && r[0]) ec.one_to_zero_error += 1;
      if (md == DET_INS_OMI && !r[0]) ec.zero_to_one_error += 1;
      q.push_back(ec);
    end
    {send, flip, exp_bit, bmask, first} <= {1'b1, f, r[0], m, nb[4:0] == 5'h00};
    @(posedge clk_sys);
    prv = r[0];
    nb++;
  endtask
  task automatic burst(input int n, input string s);
    repeat (n) begin
      r = lfsr(r);
      bit1(r[5:4] == 2'b00, r[7]);
    end
    send <= 1'b0;
    tick(6);
    chk(q.size(), 0);
    $display("test %s done", s);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  // scoreboard: each error pulse takes the oldest note
  always @(negedge clk_sys) begin
    if (rst_n === 1'b1 && error_seen !== 1'b0) begin
      nt = (q.size() > 0) ? q.pop_front() : '1;
      chk(counts.total, nt.total);
      if (md == DET_TRANSITION) begin
        chk(counts.transition, nt.transition);
        chk(counts.non_transition, nt.non_transition);
      end else begin
        chk(counts.zero_to_one_error, nt.zero_to_one_error);
        chk(counts.one_to_zero_error, nt.one_to_zero_error);
      end
    end
  end
  // watchdog; the run needs about 30k cycles
  initial begin
    tick(60000);
    n_errors++;
    $display("unexpected at %0t: run timed out", $time);
    summarize();
  end
  initial begin
    {rst_n, cfg_wr, wmask_wr, wmask_data, phase_wr, clear_counts, wmask_addr} = '0;
    {send, flip, exp_bit, bmask, first, prv, bm_on, wm_on, widx, nb, phase_req} = '0;
    {cfg_req, c, ec} = '0;
    md = DET_INS_OMI;
    {ce, r, bit_period_fs} = {1'b1, 32'h48CA, 32'h0000_9C40};
    tick(3);
    rst_n <= 1'b1;
    // odd words measured, even words masked
    for (int i = 0; i < 256; i++) begin
      {wmask_wr, wmask_addr, wmask_data, wmem[i]} <= {1'b1, 8'(i), i[0], i[0]};
      @(posedge clk_sys);
    end
    wmask_wr <= 1'b0;
    c.pattern = PAT_DATA;
    wcfg(c, 1'b0, c);
    burst(200, "plain");
    c.block_mask_en = 1'b1;
    wcfg(c, 1'b0, c);
    burst(200, "block mask");
    c.block_mask_en = 1'b0;
    wcfg(c, 1'b0, c);
    // prbs, mixed: mask refused and dropped; then capture on, mask refused
    for (int k = 0; k < 4; k++) begin
      w = c;
      w.pattern = (k == 0) ? PAT_PRBS : (k == 1) ? PAT_MIXED : PAT_DATA;
      w.capturing = k[1];
      w.block_mask_en = (k != 2);
      c = w;
      c.block_mask_en = 1'b0;
      wcfg(w, k != 2, c);
    end
    c = '0;
    c.pattern = PAT_DATA;
    wcfg(c, 1'b0, c);
    w = c;
    w.combined = 1'b1;
    w.detect = DET_TRANSITION;
    c.combined = 1'b1;
    wcfg(w, 1'b1, c);
    c.combined = 1'b0;
    c.detect = DET_TRANSITION;
    wcfg(c, 1'b0, c);
    $display("test config done");
    clr();
    burst(300, "transition");
    c.word_mask_en = 1'b1;
    wcfg(c, 1'b0, c);
    clr();
    burst(320, "word mask");
    c.word_mask_en = 1'b0;
    // one error in the first of two and a half periods
    for (int k = 0; k < 4; k++) begin
      c.interval = interval_sel_t'(k);
      wcfg(c, 1'b0, c);
      clr();
      tick(2);
      bit1(1'b1, 1'b0);
      send <= 1'b0;
      tick(25 * 10 ** k - 3);
      @(negedge clk_sys);
      chk(counts.errored_interval_count, 1);
      chk(counts.error_free_interval, 1);
      @(posedge clk_sys);
    end
    $display("test intervals done");
    r = lfsr(r);
    pv[7] = int'(r[8:0]) * 2 - 500;
    pm = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      bad = pv[i] > 1000 || pv[i] < -1000 || pv[i] % 2 != 0;
      pm = bad ? pm : pv[i];
      phase_req <= 12'(pv[i]);
      phase_wr <= 1'b1;
      @(posedge clk_sys);
      phase_wr <= 1'b0;
      @(negedge clk_sys);
      rf = phase_refused;
      @(negedge clk_sys);
      chk(rf | phase_refused, bad);
      chk(phase_mui, pm);
      @(negedge clk_sys);
      chk(phase_fs, pm * 40000 / 1000);
    end
    @(posedge clk_sys);
    bit_period_fs <= 32'h0006_5900;
    tick(3);
    @(negedge clk_sys);
    chk(phase_fs, pm * 416);
    $display("test phase done");
    summarize();
  end
endmodule // test_bit_error_counter_masking
